// File: core/fbws_buffer.sv
// write buffer words with registered read port and fill to all ones
`timescale 1ns/1ps
module fbws_buffer #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 4,
  parameter logic [WIDTH-1:0] FILL = '1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // write side
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_idx,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic fill_all,
  // read side
  input wire logic [$clog2(DEPTH)-1:0] rd_idx,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] word_reg [DEPTH];

  if (DEPTH < 2) begin : g_check
    $error("fbws_buffer needs at least two words");
  end

  // ==================================================
  // storage: fill wins over a load in the same cycle
  for (genvar i = 0; i < DEPTH; i++) begin : g_word
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        word_reg[i] <= '1;
      end else if (fill_all) begin
        word_reg[i] <= FILL;
      end else if (wr_en && (wr_idx == i)) begin
        word_reg[i] <= wr_data;
      end
    end
  end

  // registered read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data <= '1;
    end else begin
      rd_data <= word_reg[rd_idx];
    end
  end
endmodule // fbws_buffer

// File: core/fbws_defines.svh
// constants of the flash block write sequencer: offsets, bit positions, resets, times
`ifndef FBWS_DEFINES_SVH
`define FBWS_DEFINES_SVH

// ==================================================
// register indexes (byte address is four times the index)
`define FBWS_IDX_FLAGS_TWO 10'h00d
`define FBWS_IDX_ENABLES_TWO 10'h08d
`define FBWS_IDX_DATA_LOW 10'h10c
`define FBWS_IDX_ADDR_LOW 10'h10d
`define FBWS_IDX_DATA_HIGH 10'h10e
`define FBWS_IDX_ADDR_HIGH 10'h10f
`define FBWS_IDX_CONTROL 10'h18c
`define FBWS_IDX_UNLOCK 10'h18d

// ==================================================
// field positions and widths
`define FBWS_CTL_PGS_BIT 7
`define FBWS_CTL_ERR_BIT 3
`define FBWS_CTL_WRITE_ENABLE_BIT_BIT 2
`define FBWS_CTL_WR_BIT 1
`define FBWS_DONE_BIT 4
`define FBWS_DONE_EN_BIT 4
`define FBWS_DATA_HIGH_W 6
`define FBWS_ADDR_HIGH_W 3
`define FBWS_WORD_W 14
`define FBWS_BUF_DEPTH 4

// ==================================================
// reset values and key values
`define FBWS_RST_BYTE 8'h00
`define FBWS_BUF_RESET 14'h3fff
`define FBWS_KEY_FIRST 8'h55
`define FBWS_KEY_SECOND 8'haa
`define FBWS_LAST_WORD 2'h3

// ==================================================
// times and derived cycle counts
`define FBWS_CLK_HZ 20000000
`define FBWS_PWRT_MS 72
`define FBWS_LONG_WRITE_MS 2
`define FBWS_PWRT_CYCLES (`FBWS_PWRT_MS * (`FBWS_CLK_HZ / 1000))
`define FBWS_LONG_WRITE_CYCLES (`FBWS_LONG_WRITE_MS * (`FBWS_CLK_HZ / 1000))

`endif

// File: core/fbws_pkg.sv
// types of the flash block write sequencer
package fbws_pkg;
  // ==================================================
  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SHORT,
    ST_LONG_EXEC,
    ST_LONG_SKIP,
    ST_LONG_PROG,
    ST_LONG_WAIT,
    ST_DATA_WAIT
  } fbws_state_type;
endpackage

// File: core/fbws_top.sv
// flash block write sequencer: apb registers, unlock, buffer loads, long write
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`include "fbws_defines.svh"

module fbws_top #(
  parameter int PWRT_CYCLES = `FBWS_PWRT_CYCLES,
  parameter int LONG_WRITE_CYCLES = `FBWS_LONG_WRITE_CYCLES,
  parameter logic [10:0] PROT_TOP_00 = 11'h7ff,
  parameter logic [10:0] PROT_TOP_01 = 11'h3ff,
  parameter logic [10:0] PROT_TOP_10 = 11'h0ff
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // configuration pins
  input wire logic [1:0] write_protect_range,
  input wire logic code_protect_data,
  input wire logic code_protect_prog,
  // core control
  output logic write_halt_signal,
  output logic ignore_slot,
  // program flash write port
  output logic prog_word_strobe,
  output logic [10:0] prog_word_addr,
  output logic [13:0] prog_word_data,
  // data memory write port
  output logic data_nvm_wr_req,
  output logic [7:0] data_nvm_addr,
  output logic [7:0] data_nvm_data,
  input wire logic data_nvm_done,
  // external access gates
  output logic ext_prog_read_allow,
  output logic ext_prog_write_allow,
  output logic ext_data_access_allow
);
  localparam int WAIT_W = $clog2(LONG_WRITE_CYCLES + 1);
  localparam int PWRT_W = $clog2(PWRT_CYCLES + 1);

  if (LONG_WRITE_CYCLES < 8 || PWRT_CYCLES < 1) begin : g_check
    $error("fbws_top: long write needs 8 cycles or more, power-up timer 1 or more");
  end

  // ==================================================
  // helpers
  function automatic logic reg_hit(input logic [11:0] addr, input logic [9:0] idx);
    reg_hit = (addr[11:2] == idx) && (addr[1:0] == 2'h0);
  endfunction

  function automatic logic is_protected(input logic [10:0] addr, input logic [1:0] range);
    case (range)
      2'h0: is_protected = (addr <= PROT_TOP_00);
      2'h1: is_protected = (addr <= PROT_TOP_01);
      2'h2: is_protected = (addr <= PROT_TOP_10);
      default: is_protected = 1'b0;
    endcase
  endfunction

  // ==================================================
  // registers and state
  fbws_pkg::fbws_state_type state_reg;
  logic [7:0] data_low_reg;
  logic [7:0] addr_low_reg;
  logic [`FBWS_DATA_HIGH_W-1:0] data_high_reg;
  logic [`FBWS_ADDR_HIGH_W-1:0] addr_high_reg;
  logic pgs_reg;
  logic write_enable_bit_reg;
  logic wr_reg;
  logic err_reg;
  logic nvm_done_reg;
  logic done_en_reg;
  logic [1:0] unlock_stage;
  logic pwrt_done_reg;
  logic [PWRT_W-1:0] pwrt_cnt;
  logic [WAIT_W-1:0] wait_cnt;
  logic [1:0] prog_cnt;
  logic fetch_v;
  logic [1:0] fetch_idx;
  logic [8:0] block_base;
  logic [4:0] sync_a;
  logic [4:0] sync_b;
  logic done_seen;
  logic [13:0] buf_rd_data;

  // synchronised pins: first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= 5'h00;
      sync_b <= 5'h00;
      done_seen <= 1'b0;
    end else begin
      sync_a <= {data_nvm_done, code_protect_prog, code_protect_data, write_protect_range};
      sync_b <= sync_a;
      done_seen <= sync_b[4];
    end
  end

  logic [1:0] wp_sync;
  logic cp_data_sync;
  logic cp_prog_sync;
  logic data_done_rise;
  assign wp_sync = sync_b[1:0];
  assign cp_data_sync = sync_b[2];
  assign cp_prog_sync = sync_b[3];
  assign data_done_rise = sync_b[4] && !done_seen;

  // ==================================================
  // apb decode
  logic acc;
  logic setup;
  logic mapped;
  logic [10:0] nvm_addr;
  logic [13:0] load_word;
  logic ctl_wr;
  logic start_req;
  logic long_req;
  logic long_prot;
  logic start_ok;
  logic wait_last;
  logic flags_wr;

  assign acc = psel && penable && pready;
  assign setup = psel && !penable;
  assign mapped = reg_hit(paddr, `FBWS_IDX_FLAGS_TWO) || reg_hit(paddr, `FBWS_IDX_ENABLES_TWO)
    || reg_hit(paddr, `FBWS_IDX_DATA_LOW) || reg_hit(paddr, `FBWS_IDX_ADDR_LOW)
    || reg_hit(paddr, `FBWS_IDX_DATA_HIGH) || reg_hit(paddr, `FBWS_IDX_ADDR_HIGH)
    || reg_hit(paddr, `FBWS_IDX_CONTROL) || reg_hit(paddr, `FBWS_IDX_UNLOCK);
  assign nvm_addr = {addr_high_reg, addr_low_reg};
  assign load_word = {data_high_reg, data_low_reg};
  assign ctl_wr = acc && pwrite && reg_hit(paddr, `FBWS_IDX_CONTROL);
  assign flags_wr = acc && pwrite && reg_hit(paddr, `FBWS_IDX_FLAGS_TWO);
  // start needs write enable already set, fresh unlock, idle, timer done
  assign start_req = ctl_wr && pwdata[`FBWS_CTL_WR_BIT] && write_enable_bit_reg
    && (unlock_stage == 2'h2) && (state_reg == fbws_pkg::ST_IDLE)
    && pwrt_done_reg;
  assign long_req = pgs_reg && (addr_low_reg[1:0] == `FBWS_LAST_WORD);
  assign long_prot = long_req && is_protected(nvm_addr, wp_sync);
  assign start_ok = start_req && !long_prot;
  assign wait_last = (wait_cnt == WAIT_W'(LONG_WRITE_CYCLES - 1));

  // apb answer: one wait-free access phase, data captured in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      prdata <= 32'h0000_0000;
      if (setup && !pwrite) begin
        if (reg_hit(paddr, `FBWS_IDX_FLAGS_TWO)) begin
          prdata[`FBWS_DONE_BIT] <= nvm_done_reg;
        end
        if (reg_hit(paddr, `FBWS_IDX_ENABLES_TWO)) begin
          prdata[`FBWS_DONE_EN_BIT] <= done_en_reg;
        end
        if (reg_hit(paddr, `FBWS_IDX_DATA_LOW)) begin
          prdata[7:0] <= data_low_reg;
        end
        if (reg_hit(paddr, `FBWS_IDX_ADDR_LOW)) begin
          prdata[7:0] <= addr_low_reg;
        end
        if (reg_hit(paddr, `FBWS_IDX_DATA_HIGH)) begin
          prdata[`FBWS_DATA_HIGH_W-1:0] <= data_high_reg;
        end
        if (reg_hit(paddr, `FBWS_IDX_ADDR_HIGH)) begin
          prdata[`FBWS_ADDR_HIGH_W-1:0] <= addr_high_reg;
        end
        if (reg_hit(paddr, `FBWS_IDX_CONTROL)) begin
          prdata[`FBWS_CTL_PGS_BIT] <= pgs_reg;
          prdata[`FBWS_CTL_ERR_BIT] <= err_reg;
          prdata[`FBWS_CTL_WRITE_ENABLE_BIT_BIT] <= write_enable_bit_reg;
          prdata[`FBWS_CTL_WR_BIT] <= wr_reg;
        end
      end
    end
  end

  // ==================================================
  // address and data registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_low_reg <= `FBWS_RST_BYTE;
      addr_low_reg <= `FBWS_RST_BYTE;
      data_high_reg <= `FBWS_DATA_HIGH_W'(`FBWS_RST_BYTE);
      addr_high_reg <= `FBWS_ADDR_HIGH_W'(`FBWS_RST_BYTE);
      done_en_reg <= 1'b0;
    end else if (acc && pwrite) begin
      if (reg_hit(paddr, `FBWS_IDX_DATA_LOW)) begin
        data_low_reg <= pwdata[7:0];
      end
      if (reg_hit(paddr, `FBWS_IDX_ADDR_LOW)) begin
        addr_low_reg <= pwdata[7:0];
      end
      if (reg_hit(paddr, `FBWS_IDX_DATA_HIGH)) begin
        data_high_reg <= pwdata[`FBWS_DATA_HIGH_W-1:0];
      end
      if (reg_hit(paddr, `FBWS_IDX_ADDR_HIGH)) begin
        addr_high_reg <= pwdata[`FBWS_ADDR_HIGH_W-1:0];
      end
      if (reg_hit(paddr, `FBWS_IDX_ENABLES_TWO)) begin
        done_en_reg <= pwdata[`FBWS_DONE_EN_BIT];
      end
    end
  end

  // control bits: enable cleared at power-up, select and enable free to change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pgs_reg <= 1'b0;
      write_enable_bit_reg <= 1'b0;
    end else if (ctl_wr) begin
      pgs_reg <= pwdata[`FBWS_CTL_PGS_BIT];
      write_enable_bit_reg <= pwdata[`FBWS_CTL_WRITE_ENABLE_BIT_BIT];
    end
  end

  // error flag: refused protected block write sets it, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_reg <= 1'b0;
    end else if (start_req && long_prot) begin
      err_reg <= 1'b1;
    end else if (ctl_wr) begin
      err_reg <= err_reg && pwdata[`FBWS_CTL_ERR_BIT];
    end
  end

  // done flag: set at end of write, software may only clear, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nvm_done_reg <= 1'b0;
    end else if ((state_reg == fbws_pkg::ST_LONG_WAIT && wait_last)
                 || (state_reg == fbws_pkg::ST_DATA_WAIT && data_done_rise)) begin
      nvm_done_reg <= 1'b1;
    end else if (flags_wr) begin
      nvm_done_reg <= nvm_done_reg && pwdata[`FBWS_DONE_BIT];
    end
  end

  // unlock detector: port keeps no value, any other write breaks the chain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlock_stage <= 2'h0;
    end else if (acc && pwrite) begin
      if (reg_hit(paddr, `FBWS_IDX_UNLOCK)) begin
        if (pwdata[7:0] == `FBWS_KEY_FIRST) begin
          unlock_stage <= 2'h1;
        end else if (pwdata[7:0] == `FBWS_KEY_SECOND && unlock_stage == 2'h1) begin
          unlock_stage <= 2'h2;
        end else begin
          unlock_stage <= 2'h0;
        end
      end else begin
        unlock_stage <= 2'h0;
      end
    end
  end

  // power-up timer: no write starts until it expires
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwrt_cnt <= '0;
      pwrt_done_reg <= 1'b0;
    end else if (!pwrt_done_reg) begin
      pwrt_cnt <= pwrt_cnt + PWRT_W'(1);
      pwrt_done_reg <= (pwrt_cnt == PWRT_W'(PWRT_CYCLES - 1));
    end
  end

  // ==================================================
  // sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= fbws_pkg::ST_IDLE;
      wr_reg <= 1'b0;
      prog_cnt <= 2'h0;
      wait_cnt <= '0;
      block_base <= 9'h000;
    end else begin
      case (state_reg)
        fbws_pkg::ST_IDLE: begin
          if (start_ok) begin
            wr_reg <= 1'b1;
            block_base <= nvm_addr[10:2];
            if (!pgs_reg) begin
              state_reg <= fbws_pkg::ST_DATA_WAIT;
            end else if (long_req) begin
              state_reg <= fbws_pkg::ST_LONG_EXEC;
            end else begin
              state_reg <= fbws_pkg::ST_SHORT;
            end
          end
        end
        fbws_pkg::ST_SHORT: begin
          wr_reg <= 1'b0;
          state_reg <= fbws_pkg::ST_IDLE;
        end
        fbws_pkg::ST_LONG_EXEC: begin
          state_reg <= fbws_pkg::ST_LONG_SKIP;
        end
        fbws_pkg::ST_LONG_SKIP: begin
          prog_cnt <= 2'h0;
          state_reg <= fbws_pkg::ST_LONG_PROG;
        end
        fbws_pkg::ST_LONG_PROG: begin
          prog_cnt <= prog_cnt + 2'h1;
          wait_cnt <= '0;
          if (prog_cnt == `FBWS_LAST_WORD) begin
            state_reg <= fbws_pkg::ST_LONG_WAIT;
          end
        end
        fbws_pkg::ST_LONG_WAIT: begin
          wait_cnt <= wait_cnt + WAIT_W'(1);
          if (wait_last) begin
            wr_reg <= 1'b0;
            state_reg <= fbws_pkg::ST_IDLE;
          end
        end
        fbws_pkg::ST_DATA_WAIT: begin
          if (data_done_rise) begin
            wr_reg <= 1'b0;
            state_reg <= fbws_pkg::ST_IDLE;
          end
        end
        default: begin
          state_reg <= fbws_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // core control: one executed slot, one ignored slot, then halt until done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_halt_signal <= 1'b0;
      ignore_slot <= 1'b0;
    end else begin
      ignore_slot <= (state_reg == fbws_pkg::ST_LONG_EXEC);
      write_halt_signal <= (state_reg == fbws_pkg::ST_LONG_SKIP)
        || (state_reg == fbws_pkg::ST_LONG_PROG)
        || (state_reg == fbws_pkg::ST_LONG_WAIT && !wait_last);
    end
  end

  // ==================================================
  // buffer: load on short or long start, refill with ones after a long write
  logic buf_wr;
  logic buf_fill;
  assign buf_wr = (state_reg == fbws_pkg::ST_SHORT) || (state_reg == fbws_pkg::ST_LONG_EXEC);
  assign buf_fill = (state_reg == fbws_pkg::ST_LONG_WAIT) && wait_last;

  fbws_buffer #(
    .WIDTH(`FBWS_WORD_W),
    .DEPTH(`FBWS_BUF_DEPTH),
    .FILL(`FBWS_BUF_RESET)
  ) u_buffer (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(buf_wr),
    .wr_idx(addr_low_reg[1:0]),
    .wr_data(load_word),
    .fill_all(buf_fill),
    .rd_idx(prog_cnt),
    .rd_data(buf_rd_data)
  );

  // program port: four words of the aligned block, one strobe each
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch_v <= 1'b0;
      fetch_idx <= 2'h0;
      prog_word_strobe <= 1'b0;
      prog_word_addr <= 11'h000;
      prog_word_data <= `FBWS_BUF_RESET;
    end else begin
      fetch_v <= (state_reg == fbws_pkg::ST_LONG_PROG);
      fetch_idx <= prog_cnt;
      prog_word_strobe <= fetch_v;
      if (fetch_v) begin
        prog_word_addr <= {block_base, fetch_idx};
        prog_word_data <= buf_rd_data;
      end
    end
  end

  // data memory port: one request pulse, completion comes on the done pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_nvm_wr_req <= 1'b0;
      data_nvm_addr <= 8'h00;
      data_nvm_data <= 8'h00;
    end else begin
      data_nvm_wr_req <= start_ok && !pgs_reg;
      if (start_ok && !pgs_reg) begin
        data_nvm_addr <= addr_low_reg;
        data_nvm_data <= data_low_reg;
      end
    end
  end

  // external access gates from the protection pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_prog_read_allow <= 1'b0;
      ext_prog_write_allow <= 1'b0;
      ext_data_access_allow <= 1'b0;
    end else begin
      ext_prog_read_allow <= !cp_prog_sync;
      ext_prog_write_allow <= !cp_prog_sync && !cp_data_sync;
      ext_data_access_allow <= !cp_data_sync;
    end
  end

  // ==================================================
  // checks
  a_short_wr_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    (start_ok && pgs_reg && !long_req) |=> wr_reg ##1 (!wr_reg && !write_halt_signal))
    else $error("short load start bit not one cycle");
  a_short_no_halt: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == fbws_pkg::ST_SHORT) |-> ##1 (!write_halt_signal && !ignore_slot))
    else $error("short load halted the core");
  a_long_halt_order: assert property (@(posedge pclk) disable iff (!presetn)
    (start_ok && long_req) |=> !ignore_slot ##1 (ignore_slot && !write_halt_signal) ##1
    (!ignore_slot && write_halt_signal) ##1 write_halt_signal[*6])
    else $error("long write halt order wrong");
  a_long_four_words: assert property (@(posedge pclk) disable iff (!presetn)
    (start_ok && long_req) |-> ##5 prog_word_strobe[*4] ##1 !prog_word_strobe)
    else $error("long write did not issue four words");
  a_wr_needs_enable: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(wr_reg) |-> ($past(write_enable_bit_reg) && $past(unlock_stage) == 2'h2))
    else $error("start set without enable or unlock");
  a_pwrt_blocks: assert property (@(posedge pclk) disable iff (!presetn)
    !pwrt_done_reg |=> !$rose(wr_reg))
    else $error("write started during power-up timer");
  a_protect_range: assert property (@(posedge pclk) disable iff (!presetn)
    (start_req && long_prot) |=> (!wr_reg && err_reg && state_reg == fbws_pkg::ST_IDLE))
    else $error("protected block write not refused");
  a_done_end: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == fbws_pkg::ST_LONG_WAIT && wait_last) |=>
    (nvm_done_reg && !wr_reg && !write_halt_signal))
    else $error("long write end not flagged");
  a_done_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    (nvm_done_reg && !flags_wr) |=> nvm_done_reg)
    else $error("done flag lost without software clear");
  a_ext_gate: assert property (@(posedge pclk) disable iff (!presetn)
    presetn |=> (ext_data_access_allow == !$past(cp_data_sync)))
    else $error("external data gate wrong");
endmodule // fbws_top

// File: verif/fbws_nvm_model.sv
// data memory model that answers write requests after a delay
`timescale 1ns/1ps
module fbws_nvm_model #(
  parameter int DELAY = 6
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // write handshake
  input wire logic data_nvm_wr_req,
  output logic data_nvm_done
);
  int cnt;
  // done is held four cycles so the synchroniser in the block cannot miss it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      data_nvm_done <= 1'b0;
    end else begin
      if (data_nvm_wr_req) cnt <= DELAY + 4;
      else if (cnt > 0) cnt <= cnt - 1;
      data_nvm_done <= (cnt > 0 && cnt <= 4);
    end
  end
endmodule // fbws_nvm_model

// File: verif/tb_fbws_top.sv
// self-checking testbench of the flash block write sequencer
`timescale 1ns/1ps
`include "fbws_defines.svh"
module tb_fbws_top;
  // ==================================================
  // pins, counters and captured words
  localparam logic [9:0] ctl_i = `FBWS_IDX_CONTROL;
  localparam logic [9:0] ul_i = `FBWS_IDX_UNLOCK;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, se, cpd, cpp;
  logic halt, ign, strb, dreq, ddone, epr, epw, eda, halt_seen, ign_seen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [1:0] wpr;
  logic [10:0] pa;
  logic [13:0] pd, ew;
  logic [7:0] da, dd;
  logic [10:0] qa[$];
  logic [13:0] qd[$];
  int fails, comparisons;
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  fbws_top #(.PWRT_CYCLES(30), .LONG_WRITE_CYCLES(16)) dut (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .write_protect_range(wpr),
    .code_protect_data(cpd), .code_protect_prog(cpp), .write_halt_signal(halt),
    .ignore_slot(ign), .prog_word_strobe(strb), .prog_word_addr(pa), .prog_word_data(pd),
    .data_nvm_wr_req(dreq), .data_nvm_addr(da), .data_nvm_data(dd), .data_nvm_done(ddone),
    .ext_prog_read_allow(epr), .ext_prog_write_allow(epw), .ext_data_access_allow(eda));
  fbws_nvm_model model (.pclk(pclk), .presetn(presetn), .data_nvm_wr_req(dreq),
    .data_nvm_done(ddone));
  // collect programmed words and core stall events
  always @(posedge pclk) begin
    if (strb === 1'b1) begin
      qa.push_back(pa);
      qd.push_back(pd);
    end
    if (halt === 1'b1) halt_seen = 1'b1;
    if (ign === 1'b1) ign_seen = 1'b1;
  end
  // ==================================================
  // tasks
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one apb transfer, request held until pready is sampled high
  task apb(input logic w, input logic [9:0] i, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {i, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // firmware word load: address, data, enable, keys, start
  task ld(input logic [10:0] a, input logic [13:0] w, input logic [7:0] c);
    apb(1'b1, `FBWS_IDX_ADDR_HIGH, {5'h0, a[10:8]});
    apb(1'b1, `FBWS_IDX_ADDR_LOW, a[7:0]);
    apb(1'b1, `FBWS_IDX_DATA_LOW, w[7:0]);
    apb(1'b1, `FBWS_IDX_DATA_HIGH, {2'h0, w[13:8]});
    apb(1'b1, ctl_i, c);
    apb(1'b1, ul_i, `FBWS_KEY_FIRST);
    apb(1'b1, ul_i, `FBWS_KEY_SECOND);
    apb(1'b1, ctl_i, c | 8'h02);
    do begin
      apb(1'b0, ctl_i, 8'h00);
    end while (r[1] !== 1'b0);
  endtask
  task finish_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // watchdog far beyond the few hundred cycles the tests need
  initial begin
    repeat (40000) @(posedge pclk);
    fails++;
    finish_test;
  end
  // ==================================================
  // tests
  initial begin
    {presetn, psel, penable, pwrite, cpd, cpp, halt_seen, ign_seen} = '0;
    paddr = '0;
    pwdata = '0;
    wpr = 2'b11;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ctl_i, 8'h00);
    chk("control reset", r, 32'h0);
    apb(1'b1, `FBWS_IDX_ADDR_LOW, 8'h03);
    apb(1'b1, ctl_i, 8'h84);
    apb(1'b1, ul_i, `FBWS_KEY_FIRST);
    apb(1'b1, ul_i, `FBWS_KEY_SECOND);
    apb(1'b1, ctl_i, 8'h86);
    repeat (30) @(posedge pclk);
    chk("halt in power-up", halt_seen, 0);
    apb(1'b1, ul_i, `FBWS_KEY_FIRST);
    apb(1'b1, ul_i, `FBWS_KEY_SECOND);
    apb(1'b1, `FBWS_IDX_DATA_LOW, 8'h11);
    apb(1'b1, ctl_i, 8'h86);
    apb(1'b0, ctl_i, 8'h00);
    chk("broken unlock start", {halt_seen, r[1]}, 0);
    $display("test guards done");
    for (int i = 0; i < 4; i++) begin
      if (i == 3) chk("halt on short load", halt_seen, 0);
      ld(11'h100 + 11'(i), 14'h2a50 + 14'(i), 8'h84);
    end
    ld(11'h107, 14'h0123, 8'h84);
    for (int i = 0; i < 8; i++) begin
      chk("word addr", qa[i], 11'h100 + 11'(i));
      ew = (i == 7) ? 14'h0123 : ((i > 3) ? `FBWS_BUF_RESET : 14'h2a50 + 14'(i));
      chk("word data", qd[i], ew);
    end
    chk("stall and skip", {halt_seen, ign_seen}, 2'b11);
    apb(1'b0, `FBWS_IDX_FLAGS_TWO, 8'h00);
    chk("done flag", r[4], 1);
    $display("test block write done");
    wpr <= 2'b10;
    ld(11'h00b, 14'h0055, 8'h84);
    chk("protected words", {8'(qa.size()), r[3]}, {8'h08, 1'b1});
    wpr <= 2'b11;
    apb(1'b1, `FBWS_IDX_FLAGS_TWO, 8'h00);
    ld(11'h005, 14'h0077, 8'h04);
    apb(1'b0, `FBWS_IDX_FLAGS_TWO, 8'h00);
    chk("data write", {da, dd, r[4], 8'(qa.size())}, {8'h05, 8'h77, 1'b1, 8'h08});
    apb(1'b0, 10'h001, 8'h00);
    chk("unmapped read", {se, r[30:0]}, {1'b1, 31'h0});
    apb(1'b0, ul_i, 8'h00);
    chk("unlock port read", r, 32'h0);
    apb(1'b1, `FBWS_IDX_ADDR_LOW, 8'h0f);
    apb(1'b1, ctl_i, 8'h80);
    apb(1'b1, ul_i, `FBWS_KEY_FIRST);
    apb(1'b1, ul_i, `FBWS_KEY_SECOND);
    apb(1'b1, ctl_i, 8'h86);
    apb(1'b0, ctl_i, 8'h00);
    chk("start without enable", {r[2], r[1]}, 2'b10);
    cpp <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("program protect", {epr, epw, eda}, 3'b001);
    cpp <= 1'b0;
    cpd <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("data protect", {epr, epw, eda}, 3'b100);
    $display("test protection done");
    finish_test;
  end
endmodule // tb_fbws_top
